// file: rtl/usm_defines.svh
// Register offsets, field positions and reset values of the SPI-mode transceiver
`ifndef USM_DEFINES_SVH
`define USM_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define USM_OFF_DATA 8'h00
`define USM_OFF_STAT_A 8'h04
`define USM_OFF_CTRL_B 8'h08
`define USM_OFF_CTRL_C 8'h0C
`define USM_OFF_RATE 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define USM_A_RX_DONE 7
`define USM_A_TX_DONE 6
`define USM_A_TX_EMPTY 5
`define USM_B_TX_EMPTY_IE 5
`define USM_B_RX_EN 4
`define USM_B_TX_EN 3
`define USM_C_ORDER 2
`define USM_C_PHASE 1
`define USM_C_POLARITY 0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define USM_CTRL_B_RST 8'h00
`define USM_CTRL_C_RST 8'h06
`define USM_MODE_SPI 2'h3
`define USM_RESP_OKAY 2'h0
`define USM_RESP_SLVERR 2'h2

`endif

// file: rtl/usm_pkg.sv
// Types shared by the SPI-mode transceiver files
package usm_pkg;

    // ----------------------------------------
    // AXI4-Lite carriers
    // ----------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } usm_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } usm_axil_resp_t;

    // ----------------------------------------
    // Shift engine states
    // ----------------------------------------
    typedef enum logic [0:0] {
        USM_IDLE = 1'b0,
        USM_SHIFT = 1'b1
    } usm_state_t;

endpackage : usm_pkg

// file: rtl/usm_rx_buffer.sv
// Small receive FIFO whose head word is held in a register
`timescale 1ns/100ps
module usm_rx_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head_data,
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);

    // ----------------------------------------
    // Storage and pointers
    // ----------------------------------------
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic [WIDTH-1:0] head_ff;

    // A push into a full buffer is dropped, so older words survive
    wire do_push = push && (count_ff != DEPTH[PW:0]);
    wire do_pop = pop && (count_ff != '0);
    wire [PW-1:0] rd_next = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
    wire [PW-1:0] wr_next = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;

    assign head_data = head_ff;
    assign full = (count_ff == DEPTH[PW:0]);
    assign empty = (count_ff == '0);

    // Pointer and count update; flush drops everything at once
    always_ff @(posedge aclk) begin
        if (!aresetn || (clk_en && flush)) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (clk_en) begin
            if (do_push) begin
                wr_ptr_ff <= wr_next;
            end
            if (do_pop) begin
                rd_ptr_ff <= rd_next;
            end
            count_ff <= count_ff + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
        end
    end

    // Word store and registered head
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head_ff <= '0;
        end else if (clk_en) begin
            if (do_push) begin
                mem_ff[wr_ptr_ff] <= push_data;
            end
            if ((count_ff == '0 || (do_pop && count_ff == 1)) && do_push) begin
                head_ff <= push_data;
            end else if (do_pop && count_ff > 1) begin
                head_ff <= mem_ff[rd_next];
            end
        end
    end

endmodule : usm_rx_buffer

// file: rtl/usm_spi_master.sv
// Master-only SPI mode of the serial transceiver with an AXI4-Lite register port
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "usm_defines.svh"

// How it works
// - Empty interrupt needs enable, global enable, flag
// - Receiver enable takes over the input pin
// - Receiver disable flushes unread receive data
// - Transmitter enable takes over the output pin
// - Transmitter disable waits until all data sent
// - Mode field 11 selects master SPI
// - Format bits accepted with the mode write
// - Control C bits 5:3 read zero
// - Order bit one sends LSB first
// - Phase bit picks leading or trailing sample
// - Polarity bit sets idle clock level
// - Modes match standard SPI waveforms
// - Clock rate comes from rate divider
// - Transmit buffer ahead of shift register
// - Receive buffer beyond the shift register
// - No write-collision flag exists
// - Master only, no slave select input
// - Pins act as MOSI, MISO, SCK
// - Data write starts a full-duplex transfer
// - Overflow drops the newest received byte
// - Frame, overrun, parity flags read zero
// - Buffer-empty flag set after reset
module usm_spi_master #(
    parameter int DIV_W = 12,
    parameter int RX_DEPTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire usm_pkg::usm_axil_req_t axil_req,
    output usm_pkg::usm_axil_resp_t axil_resp,
    input wire logic global_irq_enable,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic transfer_clock_pin,
    output logic transfer_clock_oe,
    output logic rx_pin_owned,
    output logic tx_empty_irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Picks the wire bit for position n of the frame
    function automatic logic pick_bit(input logic [7:0] d, input logic [2:0] n, input logic lsb);
        pick_bit = lsb ? d[n] : d[3'd7 - n];
    endfunction : pick_bit

    // Shifts one sampled bit into the receive word
    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
        shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction : shift_in

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl_b_ff; // Interrupt and enable bits
    logic [7:0] ctrl_c_ff; // Mode and frame format
    logic [DIV_W-1:0] rate_ff; // Half-period divider
    logic [7:0] txbuf_ff; // Transmit buffer word
    logic txbuf_full_ff; // Buffer holds a word
    logic tx_done_ff; // Sticky transmit complete
    usm_pkg::usm_state_t state_ff; // Shift engine state
    logic [DIV_W-1:0] div_cnt_ff; // Counts to each clock edge
    logic half_ff; // Zero before leading edge
    logic [2:0] bit_cnt_ff; // Bit within frame
    logic [7:0] txsh_ff; // Frame being sent
    logic [7:0] rxsh_ff; // Bits received so far
    logic sck_ff;
    logic mosi_ff;
    logic tx_run_ff;
    logic rx_own_ff;
    logic irq_ff;
    logic miso_meta_ff; // First sync stage, read only by the second
    logic miso_ff;

    // ----------------------------------------
    // Bus handshake registers
    // ----------------------------------------
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire mspi = (ctrl_c_ff[7:6] == `USM_MODE_SPI);
    wire txen = ctrl_b_ff[`USM_B_TX_EN];
    wire rxen = ctrl_b_ff[`USM_B_RX_EN];
    wire lsb_first = ctrl_c_ff[`USM_C_ORDER];
    wire cpha = ctrl_c_ff[`USM_C_PHASE];
    wire cpol = ctrl_c_ff[`USM_C_POLARITY];
    wire shifting = (state_ff == usm_pkg::USM_SHIFT);

    // Edge ticks from the divider
    wire tick = shifting && (div_cnt_ff == '0);
    wire lead = tick && !half_ff;
    wire trail = tick && half_ff;
    wire last = trail && (bit_cnt_ff == 3'd7);
    wire samp = cpha ? trail : lead;
    wire [7:0] rx_word = shift_in(rxsh_ff, miso_ff, lsb_first);

    // Next frame is taken from the buffer when the shifter frees
    wire load = mspi && txbuf_full_ff && (!shifting || last);

    // Write channel both held and response slot free
    wire wr_do = !awready_ff && !wready_ff && !bvalid_ff;
    wire rd_do = axil_req.arvalid && arready_ff;
    wire [7:0] raddr = axil_req.araddr[7:0];

    wire wr_data = wr_do && (waddr_ff == `USM_OFF_DATA);
    wire wr_stat = wr_do && (waddr_ff == `USM_OFF_STAT_A) && wstrb_ff[0];
    wire wr_ctrl_b = wr_do && (waddr_ff == `USM_OFF_CTRL_B) && wstrb_ff[0];
    wire wr_ctrl_c = wr_do && (waddr_ff == `USM_OFF_CTRL_C) && wstrb_ff[0];
    wire wr_rate = wr_do && (waddr_ff == `USM_OFF_RATE);
    wire wr_hit = (waddr_ff == `USM_OFF_DATA) || (waddr_ff == `USM_OFF_STAT_A) ||
                  (waddr_ff == `USM_OFF_CTRL_B) || (waddr_ff == `USM_OFF_CTRL_C) ||
                  (waddr_ff == `USM_OFF_RATE);
    wire rd_hit = (raddr == `USM_OFF_DATA) || (raddr == `USM_OFF_STAT_A) ||
                  (raddr == `USM_OFF_CTRL_B) || (raddr == `USM_OFF_CTRL_C) ||
                  (raddr == `USM_OFF_RATE);

    // A data write is taken only while enabled and the buffer is free
    wire tx_accept = wr_data && wstrb_ff[0] && txen && mspi && !txbuf_full_ff;

    // Clearing the receiver enable drops all unread bytes
    wire rx_flush = wr_ctrl_b && !wdata_ff[`USM_B_RX_EN];

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------
    wire [7:0] rxb_head;
    wire rxb_full;
    wire rxb_empty;
    wire rx_push = samp && (bit_cnt_ff == 3'd7) && rxen;
    wire rx_pop = rd_do && (raddr == `USM_OFF_DATA);

    usm_rx_buffer #(
        .WIDTH(8),
        .DEPTH(RX_DEPTH)
    ) u_rx_buffer (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .flush(rx_flush || !rxen),
        .push(rx_push),
        .push_data(rx_word),
        .pop(rx_pop),
        .head_data(rxb_head),
        .full(rxb_full),
        .empty(rxb_empty)
    );

    // Status word; frame, overrun and parity read zero in this mode
    wire [7:0] stat_a = {!rxb_empty, tx_done_ff, !txbuf_full_ff, 5'h0_0};

    // Read multiplexer
    wire [31:0] rd_mux =
        (raddr == `USM_OFF_DATA) ? {24'h00_0000, rxb_head} :
        (raddr == `USM_OFF_STAT_A) ? {24'h00_0000, stat_a} :
        (raddr == `USM_OFF_CTRL_B) ? {24'h00_0000, ctrl_b_ff} :
        (raddr == `USM_OFF_CTRL_C) ? {24'h00_0000, ctrl_c_ff[7:6], 3'h0, ctrl_c_ff[2:0]} :
        (raddr == `USM_OFF_RATE) ? {{(32 - DIV_W){1'b0}}, rate_ff} : 32'h0000_0000;

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign axil_resp.awready = awready_ff;
    assign axil_resp.wready = wready_ff;
    assign axil_resp.bvalid = bvalid_ff;
    assign axil_resp.bresp = bresp_ff;
    assign axil_resp.arready = arready_ff;
    assign axil_resp.rvalid = rvalid_ff;
    assign axil_resp.rdata = rdata_ff;
    assign axil_resp.rresp = rresp_ff;
    // Master only: no select input exists, slaves are picked by port pins
    assign serial_out_pin = mosi_ff;
    assign serial_out_oe = tx_run_ff;
    assign transfer_clock_pin = sck_ff;
    assign transfer_clock_oe = tx_run_ff;
    assign rx_pin_owned = rx_own_ff;
    assign tx_empty_irq = irq_ff;

    // ----------------------------------------
    // Bus write channel
    // ----------------------------------------
    // Address and data are taken in either order, then answered together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= `USM_RESP_OKAY;
            waddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (clk_en) begin
            if (axil_req.awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                waddr_ff <= axil_req.awaddr[7:0];
            end
            if (axil_req.wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff <= axil_req.wdata;
                wstrb_ff <= axil_req.wstrb;
            end
            if (wr_do) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `USM_RESP_OKAY : `USM_RESP_SLVERR;
            end else if (bvalid_ff && axil_req.bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Bus read channel
    // ----------------------------------------
    // One read at a time; a data read pops the receive buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `USM_RESP_OKAY;
        end else if (clk_en) begin
            if (rd_do) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? `USM_RESP_OKAY : `USM_RESP_SLVERR;
            end else if (rvalid_ff && axil_req.rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Reserved low bits of control B are kept at zero whatever is written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_b_ff <= `USM_CTRL_B_RST;
            ctrl_c_ff <= `USM_CTRL_C_RST;
            rate_ff <= '0;
        end else if (clk_en) begin
            if (wr_ctrl_b) begin
                ctrl_b_ff <= {wdata_ff[7:3], 3'h0};
            end
            if (wr_ctrl_c) begin
                ctrl_c_ff <= {wdata_ff[7:6], 3'h0, wdata_ff[2:0]};
            end
            if (wr_rate && wstrb_ff[0]) begin
                rate_ff[7:0] <= wdata_ff[7:0];
            end
            if (wr_rate && wstrb_ff[1]) begin
                rate_ff[DIV_W-1:8] <= wdata_ff[DIV_W-1:8];
            end
        end
    end

    // ----------------------------------------
    // Transmit buffer and flags
    // ----------------------------------------
    // Completion set wins over a same-cycle software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txbuf_ff <= 8'h00;
            txbuf_full_ff <= 1'b0;
            tx_done_ff <= 1'b0;
        end else if (clk_en) begin
            if (tx_accept) begin
                txbuf_ff <= wdata_ff[7:0];
                txbuf_full_ff <= 1'b1;
            end else if (load) begin
                txbuf_full_ff <= 1'b0;
            end
            if (last && !load) begin
                tx_done_ff <= 1'b1;
            end else if (wr_stat && wdata_ff[`USM_A_TX_DONE]) begin
                tx_done_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    // Each half period lasts rate+1 cycles; two halves per bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= usm_pkg::USM_IDLE;
            div_cnt_ff <= '0;
            half_ff <= 1'b0;
            bit_cnt_ff <= 3'h0;
            txsh_ff <= 8'h00;
        end else if (clk_en) begin
            case (state_ff)
                usm_pkg::USM_IDLE: begin
                    if (load) begin
                        state_ff <= usm_pkg::USM_SHIFT;
                    end
                end
                usm_pkg::USM_SHIFT: begin
                    if (last && !load) begin
                        state_ff <= usm_pkg::USM_IDLE;
                    end
                end
                default: begin
                    state_ff <= usm_pkg::USM_IDLE;
                end
            endcase
            if (load) begin
                txsh_ff <= txbuf_ff;
                div_cnt_ff <= rate_ff;
                half_ff <= 1'b0;
                bit_cnt_ff <= 3'h0;
            end else if (tick) begin
                div_cnt_ff <= rate_ff;
                half_ff <= !half_ff;
                if (trail) begin
                    bit_cnt_ff <= bit_cnt_ff + 3'h1;
                end
            end else if (shifting) begin
                div_cnt_ff <= div_cnt_ff - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Serial lines
    // ----------------------------------------
    // Phase zero drives the first bit before the leading edge; phase one on it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_ff <= 1'b0;
            mosi_ff <= 1'b0;
            rxsh_ff <= 8'h00;
        end else if (clk_en) begin
            if (lead) begin
                sck_ff <= !cpol;
            end else if (trail || !shifting) begin
                sck_ff <= cpol;
            end
            if (load && !cpha) begin
                mosi_ff <= pick_bit(txbuf_ff, 3'h0, lsb_first);
            end else if (lead && cpha) begin
                mosi_ff <= pick_bit(txsh_ff, bit_cnt_ff, lsb_first);
            end else if (trail && !cpha && !last) begin
                mosi_ff <= pick_bit(txsh_ff, bit_cnt_ff + 3'h1, lsb_first);
            end
            if (load) begin
                rxsh_ff <= 8'h00;
            end else if (samp) begin
                rxsh_ff <= rx_word;
            end
        end
    end

    // ----------------------------------------
    // Pin ownership, interrupt, input sync
    // ----------------------------------------
    // The output pin stays owned until buffer and shifter are drained
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_run_ff <= 1'b0;
            rx_own_ff <= 1'b0;
            irq_ff <= 1'b0;
            miso_meta_ff <= 1'b0;
            miso_ff <= 1'b0;
        end else if (clk_en) begin
            tx_run_ff <= mspi && (txen || shifting || txbuf_full_ff);
            rx_own_ff <= mspi && rxen;
            irq_ff <= ctrl_b_ff[`USM_B_TX_EMPTY_IE] && global_irq_enable && !txbuf_full_ff;
            miso_meta_ff <= serial_in_pin;
            miso_ff <= miso_meta_ff;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && ctrl_b_ff[5] && global_irq_enable && !txbuf_full_ff |=> irq_ff)
        else $error("empty interrupt not raised");
    a_rx_pin_take: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mspi && rxen |=> rx_own_ff)
        else $error("input pin not taken");
    a_rx_flush_now: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rx_flush |=> rxb_empty)
        else $error("receive buffer not flushed");
    a_tx_drain_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mspi && (shifting || txbuf_full_ff) |=> serial_out_oe)
        else $error("output pin released early");
    a_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !shifting && !mspi |=> !shifting)
        else $error("transfer outside SPI mode");
    a_resv_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rd_do && raddr == `USM_OFF_CTRL_C |=> rdata_ff[5:3] == 3'h0)
        else $error("reserved bits not zero");
    a_sck_idle_level: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && !shifting |=> sck_ff == $past(cpol))
        else $error("idle clock level wrong");
    a_load_starts: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && load |=> shifting && !txbuf_full_ff && bit_cnt_ff == 3'h0)
        else $error("load did not start frame");
    a_eight_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && last |=> bit_cnt_ff == 3'h0)
        else $error("frame not eight bits");

endmodule : usm_spi_master

// file: sim/usm_slave_model.sv
// SPI loopback slave that echoes the previous frame
`timescale 1ns/100ps
module usm_slave_model (
    input wire logic sck,
    input wire logic en,
    input wire logic mosi,
    input wire logic [2:0] fmt,
    output logic miso,
    output logic [7:0] rx
);
    logic [7:0] sr = 8'h5A; // First reply, arbitrary
    assign miso = fmt[2] ? sr[0] : sr[7];
    assign rx = sr;
    // Shift only while the master owns the clock, so idle level changes are not edges
    always @(sck) begin
        if (en && (sck ^ fmt[0] ^ fmt[1])) begin
            sr <= fmt[2] ? {mosi, sr[7:1]} : {sr[6:0], mosi};
        end
    end
endmodule : usm_slave_model

// file: sim/usm_spi_master_bench.sv
// Self-checking bench of the SPI-mode transceiver
`timescale 1ns/100ps
`include "usm_defines.svh"
module usm_spi_master_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic gie = 1'b0; // Global interrupt enable
    logic [2:0] fmt = 3'h0; // Format mirrored to the slave
    logic [7:0] prev = 8'h5A; // Byte the slave echoes next
    logic [31:0] d;
    int num_errors = 0;
    int cmp_count = 0;
    usm_pkg::usm_axil_req_t req = '0;
    usm_pkg::usm_axil_resp_t resp;
    logic miso, mosi, sck, mo_oe, ck_oe, rx_own, irq;
    logic [7:0] srx;
    usm_spi_master u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .axil_req(req), .axil_resp(resp),
        .global_irq_enable(gie), .serial_in_pin(miso), .serial_out_pin(mosi), .serial_out_oe(mo_oe),
        .transfer_clock_pin(sck), .transfer_clock_oe(ck_oe), .rx_pin_owned(rx_own), .tx_empty_irq(irq));
    usm_slave_model u_slave (.sck(sck), .en(ck_oe), .mosi(mosi), .fmt(fmt), .miso(miso), .rx(srx));
    initial forever #10 aclk = ~aclk;
    task final_report;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // A wait that ran out ends the run
    task tmo(input int t);
        if (t >= 200) begin
            num_errors++;
            final_report();
        end
    endtask : tmo
    // Address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [7:0] v);
        int t;
        t = 0;
        @(posedge aclk);
        req.awaddr <= 32'(a);
        req.wdata <= 32'(v);
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (resp.awready) req.awvalid <= 1'b0;
            if (resp.wready) req.wvalid <= 1'b0;
        end while (resp.bvalid !== 1'b1 && t < 200);
        req.bready <= 1'b0;
        tmo(t);
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int t;
        t = 0;
        @(posedge aclk);
        req.araddr <= 32'(a);
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (resp.arready) req.arvalid <= 1'b0;
        end while (resp.rvalid !== 1'b1 && t < 200);
        v = resp.rdata;
        r = resp.rresp;
        req.rready <= 1'b0;
        tmo(t);
    endtask : rd
    task rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic [1:0] r;
        rd(a, d, r);
        chk(d, 32'(e));
        chk(32'(r), 32'(er));
    endtask : rdc
    // Poll a status bit under a bound
    task wt(input int b, input logic v);
        int t;
        logic [1:0] r;
        t = 0;
        do begin
            rd(`USM_OFF_STAT_A, d, r);
            t++;
        end while (d[b] !== v && t < 200);
        tmo(t);
    endtask : wt
    task s_reset;
        rdc(`USM_OFF_CTRL_C, 8'h06, 2'h0);
        rdc(`USM_OFF_STAT_A, 8'h20, 2'h0);
        rdc(8'h14, 8'h00, `USM_RESP_SLVERR);
        chk(mo_oe, 1'b0);
        wr(`USM_OFF_CTRL_B, 8'h20);
        gie <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1);
        gie <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
    endtask : s_reset
    // One frame in format m; the slave answers with the previous byte
    task s_xfer(input logic [2:0] m, input logic [7:0] v);
        wr(`USM_OFF_CTRL_B, 8'h00);
        fmt <= m;
        wr(`USM_OFF_CTRL_C, {5'h18, m});
        wr(`USM_OFF_RATE, 8'h02);
        wr(`USM_OFF_CTRL_B, 8'h18);
        // Pin ownership is registered one cycle after the enable write lands
        @(posedge aclk);
        chk(sck, m[0]);
        chk({rx_own, mo_oe, ck_oe}, 3'h7);
        wr(`USM_OFF_DATA, v);
        wt(7, 1'b1);
        rdc(`USM_OFF_DATA, prev, 2'h0);
        chk(srx, v);
        prev = v;
    endtask : s_xfer
    // Three queued bytes, late disable, overflow and flush
    task s_buf;
        wr(`USM_OFF_STAT_A, 8'h40);
        wr(`USM_OFF_DATA, 8'h11);
        wr(`USM_OFF_DATA, 8'h22);
        wt(5, 1'b1);
        wr(`USM_OFF_DATA, 8'h33);
        wr(`USM_OFF_CTRL_B, 8'h10);
        chk(mo_oe, 1'b1);
        wt(6, 1'b1);
        chk(mo_oe, 1'b0);
        rdc(`USM_OFF_DATA, prev, 2'h0);
        rdc(`USM_OFF_DATA, 8'h11, 2'h0);
        rdc(`USM_OFF_STAT_A, 8'h60, 2'h0);
        wr(`USM_OFF_CTRL_B, 8'h18);
        wr(`USM_OFF_DATA, 8'h44);
        wt(7, 1'b1);
        wr(`USM_OFF_CTRL_B, 8'h08);
        rdc(`USM_OFF_STAT_A, 8'h60, 2'h0);
        chk(rx_own, 1'b0);
    endtask : s_buf
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        s_reset();
        for (int i = 0; i < 8; i++) s_xfer(3'(i), 8'(8'hA5 + i * 29));
        s_buf();
        final_report();
    end
endmodule : usm_spi_master_bench
